// File: pkg/lvrst_defines.vh
// constants for the supply voltage reset and reset flag block
//
// Overview of operation
// - monitoring enabled by threshold byte stays active except in sleep
// - reset and supply flag only after low supply outlasts minimum duration
// - low supply shorter than minimum duration is ignored, flags untouched
// - threshold byte decodes to five levels plus disable; default lowest level
// - undefined threshold code resets after delay, restores default, sets fault flag
// - genuine low supply reset keeps the threshold byte unchanged
// - supply reset flag set by low voltage reset, cleared by software or power-on
// - selection fault flag set on undefined code, cleared by software or power-on
// - upper four bits of reset cause flags always read zero
// - writing key value to flash control one resets whole device
// - watchdog timeout in run mode acts like low voltage reset, sets timeout
// - watchdog timeout in sleep clears pc and sp, sets timeout and power down
// - power-on clears timeout and power down; supply reset keeps them
// - power-on disables interrupts, clears watchdog, timers off, ports input, stack top
// - supply voltage reset is a full device reset
`ifndef LVRST_DEFINES_VH
`define LVRST_DEFINES_VH

// register addresses
`define LVRST_ADDR_THRESH 4'h0
`define LVRST_ADDR_FLAGS 4'h1
`define LVRST_ADDR_STATUS 4'h2
`define LVRST_ADDR_FLASH1 4'h3
`define LVRST_ADDR_IRQ_STAT 4'h4
`define LVRST_ADDR_IRQ_EN 4'h5
`define LVRST_ADDR_IRQ_CLR 4'h6

// threshold codes
`define LVRST_CODE_1V70 8'h66
`define LVRST_CODE_1V90 8'h55
`define LVRST_CODE_2V55 8'h33
`define LVRST_CODE_3V15 8'h99
`define LVRST_CODE_3V80 8'hAA
`define LVRST_CODE_OFF 8'hF0
`define LVRST_THRESH_RESET 8'h66
`define LVRST_FLASH_KEY 8'h55

// flag bit positions
`define LVRST_BIT_WDC 0
`define LVRST_BIT_SELF 1
`define LVRST_BIT_SUPPLY 2
`define LVRST_BIT_CTRL 3
`define LVRST_BIT_PDF 0
`define LVRST_BIT_TO 1

// timing
`define LVRST_MIN_LV_NS 120
`define LVRST_SW_DELAY_NS 50
`define LVRST_CLK_NS 5
`define LVRST_PULSE_CYC 4

`endif

// File: core/lvrst_core.v
// supply voltage reset, self-programming reset, watchdog reset and reset flags
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "lvrst_defines.vh"

module lvrst_core
#(
    parameter MIN_LV_CYC = (`LVRST_MIN_LV_NS + `LVRST_CLK_NS - 1) / `LVRST_CLK_NS,
    parameter SW_DELAY_CYC = (`LVRST_SW_DELAY_NS + `LVRST_CLK_NS - 1) / `LVRST_CLK_NS,
    parameter CNT_W = 16
)
(
    // clock and power-on reset
    input wire clk_sys,
    input wire reset,
    // register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [7:0] reg_rdata_ff,
    // analogue and system inputs
    input wire supply_low,
    input wire sleep_mode,
    input wire watchdog_timeout,
    input wire ctrl_byte_fault,
    input wire watchdog_ctrl_fault,
    // reset outputs
    output reg device_reset_ff,
    output reg pc_sp_clear_ff,
    output reg [2:0] threshold_level_ff,
    output reg monitor_on_ff,
    output reg irq_ff
);

    // pin synchronisers, three stages
    reg [2:0] low_sync_ff;
    reg [2:0] sleep_sync_ff;
    reg [2:0] wdt_sync_ff;
    reg low_q_ff;
    reg sleep_q_ff;
    reg wdt_q_ff;
    reg wdt_prev_ff;

    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            low_sync_ff <= 3'h0;
            sleep_sync_ff <= 3'h0;
            wdt_sync_ff <= 3'h0;
            low_q_ff <= 1'b0;
            sleep_q_ff <= 1'b0;
            wdt_q_ff <= 1'b0;
            wdt_prev_ff <= 1'b0;
        end
        else
        begin
            low_sync_ff <= {low_sync_ff[1:0], supply_low};
            sleep_sync_ff <= {sleep_sync_ff[1:0], sleep_mode};
            wdt_sync_ff <= {wdt_sync_ff[1:0], watchdog_timeout};
            if (low_sync_ff[1] == low_sync_ff[2])
                low_q_ff <= low_sync_ff[2];
            if (sleep_sync_ff[1] == sleep_sync_ff[2])
                sleep_q_ff <= sleep_sync_ff[2];
            if (wdt_sync_ff[1] == wdt_sync_ff[2])
                wdt_q_ff <= wdt_sync_ff[2];
            wdt_prev_ff <= wdt_q_ff;
        end
    end

    wire wdt_event = wdt_q_ff & ~wdt_prev_ff;

    // register state
    reg [7:0] thresh_ff;
    reg [3:0] cause_ff;
    reg to_ff;
    reg pdf_ff;
    reg [CNT_W-1:0] lv_cnt_ff;
    reg [CNT_W-1:0] sw_cnt_ff;
    reg sw_busy_ff;
    reg [2:0] pulse_ff;
    reg [3:0] irq_stat_ff;
    reg [3:0] irq_en_ff;

    // threshold decode into level index, 7 for off, 6 undefined
    reg [2:0] nxt_level;
    always @*
    begin
        case (thresh_ff)
            `LVRST_CODE_1V70: nxt_level = 3'h0;
            `LVRST_CODE_1V90: nxt_level = 3'h1;
            `LVRST_CODE_2V55: nxt_level = 3'h2;
            `LVRST_CODE_3V15: nxt_level = 3'h3;
            `LVRST_CODE_3V80: nxt_level = 3'h4;
            `LVRST_CODE_OFF: nxt_level = 3'h7;
            default: nxt_level = 3'h6;
        endcase
    end

    wire code_bad = (nxt_level == 3'h6);
    // enabled except in sleep or when the threshold byte is off or undefined
    wire mon_en = (nxt_level <= 3'h4) & ~sleep_q_ff;
    wire lv_fire = mon_en & low_q_ff &
        (lv_cnt_ff == MIN_LV_CYC[CNT_W-1:0] - 1'b1);
    wire sw_fire = sw_busy_ff & (sw_cnt_ff == SW_DELAY_CYC[CNT_W-1:0] - 1'b1);
    wire key_fire = reg_wr & (reg_addr == `LVRST_ADDR_FLASH1) &
        (reg_wdata == `LVRST_FLASH_KEY);
    wire wdt_run = wdt_event & ~sleep_q_ff;
    wire wdt_sleep = wdt_event & sleep_q_ff;
    wire wr_flags = reg_wr & (reg_addr == `LVRST_ADDR_FLAGS);
    wire [3:0] events = {key_fire, wdt_event, sw_fire, lv_fire};

    // minimum duration filter and software reset delay
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            lv_cnt_ff <= {CNT_W{1'b0}};
            sw_cnt_ff <= {CNT_W{1'b0}};
            sw_busy_ff <= 1'b0;
        end
        else
        begin
            if (!(mon_en & low_q_ff) || lv_fire)
                lv_cnt_ff <= {CNT_W{1'b0}};
            else
                lv_cnt_ff <= lv_cnt_ff + 1'b1;
            if (sw_fire)
            begin
                sw_busy_ff <= 1'b0;
                sw_cnt_ff <= {CNT_W{1'b0}};
            end
            else if (sw_busy_ff)
                sw_cnt_ff <= sw_cnt_ff + 1'b1;
            else if (code_bad)
                sw_busy_ff <= 1'b1;
        end
    end

    // threshold byte and flags; hardware set wins over software clear
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            thresh_ff <= `LVRST_THRESH_RESET;
            cause_ff <= 4'h0;
            to_ff <= 1'b0;
            pdf_ff <= 1'b0;
        end
        else
        begin
            // restore on fault, keep on low supply
            if (sw_fire)
                thresh_ff <= `LVRST_THRESH_RESET;
            else if (reg_wr && reg_addr == `LVRST_ADDR_THRESH && !lv_fire)
                thresh_ff <= reg_wdata;
            cause_ff[`LVRST_BIT_SUPPLY] <= lv_fire |
                (cause_ff[`LVRST_BIT_SUPPLY] & ~(wr_flags & ~reg_wdata[2]));
            cause_ff[`LVRST_BIT_SELF] <= sw_fire |
                (cause_ff[`LVRST_BIT_SELF] & ~(wr_flags & ~reg_wdata[1]));
            cause_ff[`LVRST_BIT_CTRL] <= ctrl_byte_fault |
                (cause_ff[`LVRST_BIT_CTRL] & ~(wr_flags & ~reg_wdata[3]));
            cause_ff[`LVRST_BIT_WDC] <= watchdog_ctrl_fault |
                (cause_ff[`LVRST_BIT_WDC] & ~(wr_flags & ~reg_wdata[0]));
            if (wdt_event)
                to_ff <= 1'b1;
            if (wdt_sleep)
                pdf_ff <= 1'b1;
        end
    end

    // any source of a full device reset, fault bytes included
    wire full_fire = lv_fire | sw_fire | key_fire | wdt_run |
        ctrl_byte_fault | watchdog_ctrl_fault;
    // pulse reload, cut to the counter width on purpose
    localparam [31:0] PULSE_RELOAD = `LVRST_PULSE_CYC - 1;
    wire [2:0] pulse_init = PULSE_RELOAD[2:0];

    // full reset pulse; sleep timeout only clears pc and sp
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            pulse_ff <= 3'h0;
            device_reset_ff <= 1'b1;
            pc_sp_clear_ff <= 1'b1;
        end
        else
        begin
            if (full_fire)
                pulse_ff <= pulse_init;
            else if (pulse_ff != 3'h0)
                pulse_ff <= pulse_ff - 1'b1;
            // every full reset source also raises the pc and sp clear
            device_reset_ff <= (pulse_ff != 3'h0) | full_fire;
            pc_sp_clear_ff <= (pulse_ff != 3'h0) | full_fire | wdt_sleep;
        end
    end

    // interrupt status, enable and clear
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            irq_stat_ff <= 4'h0;
            irq_en_ff <= 4'h0;
            irq_ff <= 1'b0;
        end
        else
        begin
            irq_stat_ff <= events | (irq_stat_ff &
                ~((reg_wr && reg_addr == `LVRST_ADDR_IRQ_CLR) ? reg_wdata[3:0] : 4'h0));
            if (reg_wr && reg_addr == `LVRST_ADDR_IRQ_EN)
                irq_en_ff <= reg_wdata[3:0];
            irq_ff <= |(irq_stat_ff & irq_en_ff);
        end
    end

    // read data, one cycle after strobe
    always @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            reg_rdata_ff <= 8'h00;
            threshold_level_ff <= 3'h0;
            monitor_on_ff <= 1'b0;
        end
        else
        begin
            threshold_level_ff <= nxt_level;
            monitor_on_ff <= mon_en;
            if (!reg_rd)
                reg_rdata_ff <= 8'h00;
            else
                case (reg_addr)
                    `LVRST_ADDR_THRESH: reg_rdata_ff <= thresh_ff;
                    `LVRST_ADDR_FLAGS: reg_rdata_ff <= {4'h0, cause_ff};
                    `LVRST_ADDR_STATUS: reg_rdata_ff <= {6'h00, to_ff, pdf_ff};
                    `LVRST_ADDR_IRQ_STAT: reg_rdata_ff <= {4'h0, irq_stat_ff};
                    `LVRST_ADDR_IRQ_EN: reg_rdata_ff <= {4'h0, irq_en_ff};
                    default: reg_rdata_ff <= 8'h00;
                endcase
        end
    end

endmodule
`default_nettype wire

// File: testbench/lvrst_core_assertions.sv
// assertion checker for the supply reset block
`timescale 1ns/100ps
`default_nettype none
module lvrst_checker
#(
    parameter MIN_LV_CYC = 24,
    parameter SW_DELAY_CYC = 10
)
(
    // clock and reset
    input wire clk_sys,
    input wire reset,
    // register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [7:0] reg_rdata_ff,
    // system inputs
    input wire supply_low,
    input wire sleep_mode,
    input wire watchdog_timeout,
    input wire ctrl_byte_fault,
    input wire watchdog_ctrl_fault,
    // reset outputs
    input wire device_reset_ff,
    input wire pc_sp_clear_ff,
    input wire [2:0] threshold_level_ff,
    input wire monitor_on_ff,
    input wire irq_ff
);
    localparam int UNDEF_MAX = SW_DELAY_CYC + 12;
    // one clock domain
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    // register and reset relations
    chk_flags_upper: assert property ($past(reg_rd) && $past(reg_addr) == 4'h1
        |-> reg_rdata_ff[7:4] == 4'h0) else $error("flag upper bits set");
    chk_sleep_monitor: assert property (sleep_mode [*8] |-> !monitor_on_ff)
        else $error("monitor on in sleep");
    chk_pulse_len: assert property ($rose(device_reset_ff) |-> device_reset_ff [*4])
        else $error("reset pulse short");
    chk_pc_with_reset: assert property (device_reset_ff |-> pc_sp_clear_ff)
        else $error("pc clear missing");
    chk_key_reset: assert property (reg_wr && reg_addr == 4'h3 && reg_wdata == 8'h55
        |-> ##[1:4] device_reset_ff) else $error("key write no reset");
    chk_level_decode: assert property (reg_wr && reg_addr == 4'h0 && reg_wdata == 8'hF0
        |-> ##[1:3] threshold_level_ff == 3'h7) else $error("off code not decoded");
    chk_undef_reset: assert property (reg_wr && reg_addr == 4'h0
        && !(reg_wdata inside {8'h66, 8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0})
        |-> ##[1:UNDEF_MAX] device_reset_ff) else $error("undefined code no reset");
    chk_sleep_timeout: assert property (sleep_mode [*8] ##1 $rose(watchdog_timeout)
        |-> ##[1:8] (pc_sp_clear_ff && !device_reset_ff)) else $error("sleep timeout");
    chk_run_timeout: assert property (!sleep_mode [*8] ##1 $rose(watchdog_timeout)
        |-> ##[1:8] device_reset_ff) else $error("run timeout no reset");
endmodule
bind lvrst_core lvrst_checker #(.MIN_LV_CYC(MIN_LV_CYC), .SW_DELAY_CYC(SW_DELAY_CYC)) chk_i (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff), .supply_low(supply_low),
    .sleep_mode(sleep_mode), .watchdog_timeout(watchdog_timeout),
    .ctrl_byte_fault(ctrl_byte_fault), .watchdog_ctrl_fault(watchdog_ctrl_fault),
    .device_reset_ff(device_reset_ff), .pc_sp_clear_ff(pc_sp_clear_ff),
    .threshold_level_ff(threshold_level_ff), .monitor_on_ff(monitor_on_ff), .irq_ff(irq_ff));
`default_nettype wire

// File: testbench/lvrst_core_bench.sv
// register level bench for the supply reset block
`timescale 1ns/100ps
`default_nettype none
module low_voltage_reset_and_flags_bench;
    logic clk_sys, reset, reg_wr, reg_rd, supply_low, sleep_mode, watchdog_timeout;
    logic ctrl_byte_fault, watchdog_ctrl_fault;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, base;
    logic [7:0] rst_seen = 8'h00;
    wire [7:0] reg_rdata_ff;
    wire [2:0] threshold_level_ff;
    wire device_reset_ff, pc_sp_clear_ff, monitor_on_ff, irq_ff;
    logic [7:0] codes [6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'hAA, 8'hF0};
    logic [7:0] lvls [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07};
    int mismatches = 0;
    int checks = 0;
    lvrst_core uut (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
        .supply_low(supply_low), .sleep_mode(sleep_mode), .watchdog_timeout(watchdog_timeout),
        .ctrl_byte_fault(ctrl_byte_fault), .watchdog_ctrl_fault(watchdog_ctrl_fault),
        .device_reset_ff(device_reset_ff), .pc_sp_clear_ff(pc_sp_clear_ff),
        .threshold_level_ff(threshold_level_ff), .monitor_on_ff(monitor_on_ff), .irq_ff(irq_ff));
    // 200 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    // count reset pulses
    always @(posedge device_reset_ff) rst_seen <= rst_seen + 8'h01;
    task close_out;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task cmp(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("BAD %s exp %h got %h", n, e, g);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 cmp("rdata", e, reg_rdata_ff);
    endtask
    task pulse_low(input int n);
        @(posedge clk_sys);
        supply_low <= 1'b1;
        cyc(n);
        supply_low <= 1'b0;
        cyc(12);
    endtask
    task pulse_wdt;
        @(posedge clk_sys);
        watchdog_timeout <= 1'b1;
        cyc(4);
        watchdog_timeout <= 1'b0;
        cyc(12);
    endtask
    task power_on;
        reset <= 1'b1;
        cyc(20);
        reset <= 1'b0;
        cyc(2);
    endtask
    // hang guard
    initial
    begin
        #100000;
        mismatches++;
        close_out();
    end
    // main sequence
    initial
    begin
        {reset, reg_wr, reg_rd, supply_low, sleep_mode, watchdog_timeout} = 6'h20;
        {ctrl_byte_fault, watchdog_ctrl_fault, reg_addr, reg_wdata} = 14'h0;
        power_on();
        rd(4'h0, 8'h66);
        rd(4'h1, 8'h00);
        rd(4'h2, 8'h00);
        rd(4'h7, 8'h00);
        for (int i = 0; i < 6; i++)
        begin
            wr(4'h0, codes[i]);
            cyc(3);
            cmp("level", lvls[i], {5'h0, threshold_level_ff});
        end
        wr(4'h0, 8'h55);
        wr(4'h5, 8'h01);
        base = rst_seen;
        pulse_low(15);
        cmp("resets", base, rst_seen);
        rd(4'h1, 8'h00);
        pulse_low(40);
        cmp("resets", base + 8'h01, rst_seen);
        rd(4'h1, 8'h04);
        rd(4'h0, 8'h55);
        cmp("irq", 8'h01, {7'h0, irq_ff});
        wr(4'h6, 8'h01);
        cyc(3);
        cmp("irq", 8'h00, {7'h0, irq_ff});
        wr(4'h1, 8'h00);
        rd(4'h1, 8'h00);
        sleep_mode <= 1'b1;
        cyc(10);
        cmp("monitor", 8'h00, {7'h0, monitor_on_ff});
        pulse_low(40);
        pulse_wdt();
        cmp("resets", base + 8'h01, rst_seen);
        rd(4'h2, 8'h03);
        sleep_mode <= 1'b0;
        cyc(10);
        cmp("monitor", 8'h01, {7'h0, monitor_on_ff});
        pulse_wdt();
        cmp("resets", base + 8'h02, rst_seen);
        pulse_low(40);
        rd(4'h2, 8'h03);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h12);
        cyc(30);
        rd(4'h1, 8'h02);
        rd(4'h0, 8'h66);
        cmp("resets", base + 8'h04, rst_seen);
        wr(4'h3, 8'h55);
        cyc(10);
        cmp("resets", base + 8'h05, rst_seen);
        ctrl_byte_fault <= 1'b1;
        watchdog_ctrl_fault <= 1'b1;
        @(posedge clk_sys);
        {ctrl_byte_fault, watchdog_ctrl_fault} <= 2'b00;
        cyc(20);
        rd(4'h1, 8'h0B);
        wr(4'h1, 8'h00);
        rd(4'h1, 8'h00);
        power_on();
        rd(4'h2, 8'h00);
        close_out();
    end
endmodule
`default_nettype wire
